// *** rtl/seep_defs.svh ***
// Shared constants for the three-wire serial memory link
`ifndef SEEP_DEFS_SVH
`define SEEP_DEFS_SVH

`define SEEP_CLK_MHZ   10
`define SEEP_CSL_NS    250
`define SEEP_CSL_CYC   ((`SEEP_CSL_NS * `SEEP_CLK_MHZ + 999) / 1000)
`define SEEP_HALF_CYC  4'h4
`define SEEP_POLL_CYC  4'h4
`define SEEP_PROG_US   3000
`define SEEP_TMR_W     24
`define SEEP_WORDS     1024
`define SEEP_AW16      6'h0A
`define SEEP_AW8       6'h0B
`define SEEP_DW16      6'h10
`define SEEP_DW8       6'h08
`define SEEP_OP_EXT    2'h0
`define SEEP_OP_WRITE  2'h1
`define SEEP_OP_READ   2'h2
`define SEEP_OP_ERASE  2'h3
`define SEEP_SUB_EWDS  2'h0
`define SEEP_SUB_WRAL  2'h1
`define SEEP_SUB_ERAL  2'h2
`define SEEP_SUB_EWEN  2'h3

`endif

// *** rtl/seep_dev.sv ***
// Serial memory device end: link shifter, self-timed programming, storage
module seep_dev
  import seep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SEEP_PROG_US * `SEEP_CLK_MHZ
) (
  // System clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Link pins
  seep_if.dev       lnk,
  // Status
  output logic      standby,
  output logic      busy
);

  seep_lnk_t  l_q;
  seep_lnk_t  l_d;
  seep_req_t  r_q;
  seep_req_t  r_d;
  seep_core_t c_q;
  seep_core_t c_d;

  localparam seep_core_t CORE_RST = '{mem: '1, default: '0};

  function automatic logic rd_bit(input logic [`SEEP_WORDS-1:0][15:0] m,
                                  input logic [10:0] a,
                                  input logic word_width_select,
                                  input logic [4:0] k);
    logic [15:0] w;
    logic [3:0]  idx;
    w   = word_width_select ? m[a[9:0]] : m[a[10:1]];
    idx = word_width_select ? ~k[3:0] : {a[0], ~k[2:0]};
    return w[idx];
  endfunction

  function automatic logic [15:0] wr_word(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic word_width_select,
                                          input logic a0);
    if (word_width_select) begin
      return d;
    end
    return a0 ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link domain: instruction shifter and read launcher

  always_comb begin
    logic [5:0] nn;
    logic [5:0] aw;
    logic [5:0] dw;
    logic [1:0] sub;
    logic       iss;
    seep_cmd_t  ic;
    nn   = l_q.n + 6'h01;
    aw   = c_q.org_s2 ? `SEEP_AW16 : `SEEP_AW8;
    dw   = c_q.org_s2 ? `SEEP_DW16 : `SEEP_DW8;
    sub  = 2'h0;
    iss  = 1'b0;
    ic   = C_EWDS;
    l_d  = l_q;
    r_d  = r_q;
    unique case (l_q.ph)
      P_WAIT: begin
        // Clocks with data low leave the state untouched
        if (lnk.di) begin
          l_d.ph    = P_SHIFT;
          l_d.n     = 6'h00;
          l_d.op    = 2'h0;
          l_d.adr   = 11'h000;
          l_d.dat   = 16'h0000;
          l_d.st_oe = 1'b0;
        end
      end
      P_SHIFT: begin
        l_d.n = nn;
        if (l_q.n < 6'h02) begin
          l_d.op = {l_q.op[0], lnk.di};
        end else if (l_q.n < 6'h02 + aw) begin
          l_d.adr = {l_q.adr[9:0], lnk.di};
        end else begin
          l_d.dat = {l_q.dat[14:0], lnk.di};
        end
        sub = c_q.org_s2 ? l_d.adr[9:8] : l_d.adr[10:9];
        if (nn == 6'h02 + aw) begin
          l_d.ph = P_WAIT;
          unique case (l_d.op)
            `SEEP_OP_READ: begin
              // Dummy zero ahead of the data
              l_d.ph    = P_READ;
              l_d.rd_oe = 1'b1;
              l_d.so    = 1'b0;
              l_d.k     = 5'h00;
            end
            `SEEP_OP_WRITE: l_d.ph = P_SHIFT;
            `SEEP_OP_ERASE: begin
              iss = 1'b1;
              ic  = C_ERASE;
            end
            `SEEP_OP_EXT: begin
              unique case (sub)
                `SEEP_SUB_EWEN: begin
                  iss = 1'b1;
                  ic  = C_EWEN;
                end
                `SEEP_SUB_EWDS: begin
                  iss = 1'b1;
                  ic  = C_EWDS;
                end
                `SEEP_SUB_ERAL: begin
                  iss = 1'b1;
                  ic  = C_ERAL;
                end
                `SEEP_SUB_WRAL: l_d.ph = P_SHIFT;
              endcase
            end
          endcase
        end else if (nn == 6'h02 + aw + dw) begin
          l_d.ph = P_WAIT;
          iss    = 1'b1;
          ic     = (l_d.op == `SEEP_OP_WRITE) ? C_WRITE : C_WRAL;
        end
      end
      P_READ: begin
        // Sequential read runs on while select stays high
        l_d.so = rd_bit(c_q.mem, l_q.adr, c_q.org_s2, l_q.k);
        if ({1'b0, l_q.k} == dw - 6'h01) begin
          l_d.k   = 5'h00;
          l_d.adr = c_q.org_s2 ? {1'b0, l_q.adr[9:0] + 10'h001} : l_q.adr + 11'h001;
        end else begin
          l_d.k = l_q.k + 5'h01;
        end
      end
    endcase
    if (iss) begin
      l_d.st_oe = (ic != C_EWEN) && (ic != C_EWDS);
      r_d.tgl   = ~r_q.tgl;
      r_d.cmd   = ic;
      r_d.adr   = l_d.adr;
      r_d.dat   = l_d.dat;
    end
  end

  // Select low is the reset of the link logic; clock pauses keep state
  always_ff @(posedge lnk.sclk or negedge lnk.sel) begin
    if (!lnk.sel) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Request survives deselect so a started cycle is not lost
  always_ff @(posedge lnk.sclk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign lnk.so_oe = lnk.sel & (l_q.rd_oe | l_q.st_oe);
  assign lnk.so_o  = l_q.st_oe ? ~c_q.busy : l_q.so;

  ////////////////////////////////////////////////////////////////////////
  // System domain: strap sync, write enable, programming timer, storage

  always_comb begin
    c_d        = c_q;
    c_d.tg_s1  = r_q.tgl;
    c_d.tg_s2  = c_q.tg_s1;
    c_d.tg_prev = c_q.tg_s2;
    c_d.org_s1 = lnk.word_width_select;
    c_d.org_s2 = c_q.org_s1;
    c_d.pe_s1  = lnk.pe;
    c_d.pe_s2  = c_q.pe_s1;
    c_d.sel_s1 = lnk.sel;
    c_d.sel_s2 = c_q.sel_s1;
    c_d.stby   = ~c_q.sel_s2 & ~c_q.busy;
    // Timer runs on the system clock only
    if (c_q.busy) begin
      if (c_q.tmr <= `SEEP_TMR_W'(1)) begin
        c_d.busy = 1'b0;
        c_d.tmr  = '0;
      end else begin
        c_d.tmr = c_q.tmr - `SEEP_TMR_W'(1);
      end
    end
    // Request fields are stable by the time the toggle is seen
    if (c_q.tg_s2 != c_q.tg_prev) begin
      unique case (r_q.cmd)
        C_EWEN: c_d.wen = 1'b1;
        C_EWDS: c_d.wen = 1'b0;
        default: begin
          if (c_q.wen && c_q.pe_s2 && !c_q.busy) begin
            c_d.busy = 1'b1;
            c_d.tmr  = `SEEP_TMR_W'(PROG_CYCLES);
            unique case (r_q.cmd)
              C_ERASE: begin
                c_d.mem[c_q.org_s2 ? r_q.adr[9:0] : r_q.adr[10:1]] =
                  wr_word(c_q.mem[c_q.org_s2 ? r_q.adr[9:0] : r_q.adr[10:1]],
                          16'hFFFF, c_q.org_s2, r_q.adr[0]);
              end
              C_WRITE: begin
                c_d.mem[c_q.org_s2 ? r_q.adr[9:0] : r_q.adr[10:1]] =
                  wr_word(c_q.mem[c_q.org_s2 ? r_q.adr[9:0] : r_q.adr[10:1]],
                          r_q.dat, c_q.org_s2, r_q.adr[0]);
              end
              C_ERAL: c_d.mem = '1;
              default: begin
                for (int i = 0; i < `SEEP_WORDS; i++) begin
                  c_d.mem[i] = c_q.org_s2 ? r_q.dat : {r_q.dat[7:0], r_q.dat[7:0]};
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign standby = c_q.stby;
  assign busy    = c_q.busy;

endmodule

// *** rtl/seep_host.sv ***
// Serial master end: divides the system clock into the link clock
module seep_host
  import seep_pkg::*;
(
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [29:0] cmd_bits,
  input  wire logic [6:0]  cmd_len,
  input  wire logic [6:0]  cmd_rlen,
  input  wire logic        cmd_poll,
  // Response
  output logic             rsp_valid,
  output logic [31:0]      rsp_data,
  // Straps
  input  wire logic        org_val,
  input  wire logic        org_drive,
  input  wire logic        pe_val,
  input  wire logic        pe_drive,
  // Link pins
  seep_if.host             lnk
);

  seep_host_t h_q;
  seep_host_t h_d;

  always_comb begin
    logic [6:0] total;
    logic       done;
    total     = (h_q.rlen == 7'h00) ? h_q.len : h_q.len + h_q.rlen - 7'h01;
    done      = 1'b0;
    h_d       = h_q;
    h_d.so_s1 = lnk.so;
    h_d.so_s2 = h_q.so_s1;
    h_d.rsp_v = 1'b0;
    unique case (h_q.st)
      H_GAP: begin
        // Minimum deselect time between instructions
        h_d.gap = h_q.gap + 4'h1;
        if (h_q.gap >= 4'(`SEEP_CSL_CYC - 1)) begin
          h_d.st = H_IDLE;
        end
      end
      H_IDLE: begin
        if (cmd_valid) begin
          h_d.st   = H_LOW;
          h_d.tx   = cmd_bits;
          h_d.len  = cmd_len;
          h_d.rlen = cmd_rlen;
          h_d.poll = cmd_poll;
          h_d.e    = 7'h00;
          h_d.div  = 4'h0;
          h_d.sel  = 1'b1;
          h_d.di   = cmd_bits[29];
          h_d.rx   = 32'h0000_0000;
        end
      end
      H_LOW: begin
        h_d.div = h_q.div + 4'h1;
        if (h_q.div == `SEEP_HALF_CYC - 4'h1) begin
          h_d.div  = 4'h0;
          h_d.sclk = 1'b1;
          h_d.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        h_d.div = h_q.div + 4'h1;
        if (h_q.div == `SEEP_HALF_CYC - 4'h1) begin
          h_d.div  = 4'h0;
          h_d.sclk = 1'b0;
          if (h_q.rlen != 7'h00 && h_q.e + 7'h01 >= h_q.len) begin
            h_d.rx = {h_q.rx[30:0], h_q.so_s2};
          end
          if (h_q.e + 7'h01 == total) begin
            if (h_q.poll) begin
              h_d.st = H_POLL;
            end else begin
              done = 1'b1;
            end
          end else begin
            h_d.e  = h_q.e + 7'h01;
            h_d.tx = {h_q.tx[28:0], 1'b0};
            h_d.di = h_q.tx[28];
            h_d.st = H_LOW;
          end
        end
      end
      H_POLL: begin
        // Clock parked low while the device programs on its own
        if (h_q.div != `SEEP_POLL_CYC) begin
          // Status is stale until the request has crossed into the device
          h_d.div = h_q.div + 4'h1;
        end else if (h_q.so_s2) begin
          done = 1'b1;
        end
      end
    endcase
    if (done) begin
      h_d.st    = H_GAP;
      h_d.gap   = 4'h0;
      h_d.sel   = 1'b0;
      h_d.di    = 1'b0;
      h_d.rsp_v = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  assign cmd_ready  = (h_q.st == H_IDLE);
  assign rsp_valid  = h_q.rsp_v;
  assign rsp_data   = h_q.rx;
  assign lnk.sel    = h_q.sel;
  assign lnk.sclk   = h_q.sclk;
  assign lnk.di     = h_q.di;
  assign lnk.org_o  = org_val;
  assign lnk.org_oe = org_drive;
  assign lnk.pe_o   = pe_val;
  assign lnk.pe_oe  = pe_drive;

endmodule

// *** rtl/seep_if.sv ***
// Pin-level link between the serial master and the memory device
interface seep_if;
  logic sel;
  logic sclk;
  logic di;
  logic so_o;
  logic so_oe;
  logic so;
  logic org_o;
  logic org_oe;
  logic word_width_select;
  logic pe_o;
  logic pe_oe;
  logic pe;

  // Released output reads high at the master
  assign so  = so_oe ? so_o : 1'b1;
  // Internal pull-ups on the straps
  assign word_width_select = org_oe ? org_o : 1'b1;
  assign pe  = pe_oe ? pe_o : 1'b1;

  modport dev  (input sel, sclk, di, word_width_select, pe, output so_o, so_oe);
  modport host (output sel, sclk, di, org_o, org_oe, pe_o, pe_oe, input so);
endinterface

// *** rtl/seep_pkg.sv ***
// Types for both ends of the serial memory link
package seep_pkg;
  `include "seep_defs.svh"

  typedef enum logic [2:0] {C_EWEN, C_EWDS, C_ERASE, C_WRITE, C_ERAL, C_WRAL} seep_cmd_t;
  typedef enum logic [1:0] {P_WAIT, P_SHIFT, P_READ} seep_ph_t;
  typedef enum logic [2:0] {H_GAP, H_IDLE, H_LOW, H_HIGH, H_POLL} seep_hst_t;

  typedef struct packed {
    seep_ph_t    ph;
    logic [5:0]  n;
    logic [1:0]  op;
    logic [10:0] adr;
    logic [15:0] dat;
    logic [4:0]  k;
    logic        so;
    logic        rd_oe;
    logic        st_oe;
  } seep_lnk_t;

  typedef struct packed {
    logic        tgl;
    seep_cmd_t   cmd;
    logic [10:0] adr;
    logic [15:0] dat;
  } seep_req_t;

  typedef struct packed {
    logic                              tg_s1;
    logic                              tg_s2;
    logic                              tg_prev;
    logic                              org_s1;
    logic                              org_s2;
    logic                              pe_s1;
    logic                              pe_s2;
    logic                              sel_s1;
    logic                              sel_s2;
    logic                              stby;
    logic                              wen;
    logic                              busy;
    logic [`SEEP_TMR_W-1:0]            tmr;
    logic [`SEEP_WORDS-1:0][15:0]      mem;
  } seep_core_t;

  typedef struct packed {
    seep_hst_t   st;
    logic [3:0]  div;
    logic [3:0]  gap;
    logic [6:0]  e;
    logic [6:0]  len;
    logic [6:0]  rlen;
    logic [29:0] tx;
    logic [31:0] rx;
    logic        poll;
    logic        so_s1;
    logic        so_s2;
    logic        sel;
    logic        sclk;
    logic        di;
    logic        rsp_v;
  } seep_host_t;
endpackage

// *** test/seep_properties.sv ***
// Concurrent checks on the link pins and device status
module seep_properties #(
  parameter int unsigned PROG_CYCLES = 50
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  input wire logic sel,
  input wire logic sclk,
  input wire logic di,
  input wire logic so_o,
  input wire logic so_oe,
  // Device status
  input wire logic busy,
  input wire logic standby
);
  int unsigned busy_cnt_q;
  int unsigned busy_cnt_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Length of the current busy run
  always_comb begin
    busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_sclk_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_sel_gap;
    !sel [*3];
  endsequence

  property p_oe_needs_sel;
    !sel |-> !so_oe;
  endproperty
  property p_oe_on_edge;
    $rose(so_oe) |-> $rose(sclk);
  endproperty
  property p_sclk_high;
    $rose(sclk) |-> s_sclk_high;
  endproperty
  property p_di_hold;
    $rose(sclk) |-> $stable(di) [*4];
  endproperty
  property p_sel_gap;
    $fell(sel) |-> s_sel_gap;
  endproperty
  property p_busy_status;
    busy && so_oe |-> !so_o;
  endproperty
  property p_idle_standby;
    (!sel && !busy) [*5] |-> standby;
  endproperty
  property p_sel_quiet;
    $rose(sel) |-> !so_oe;
  endproperty
  property p_prog_len;
    $fell(busy) |-> busy_cnt_q >= PROG_CYCLES && busy_cnt_q <= PROG_CYCLES + 1;
  endproperty

  a_oe_needs_sel:
    assert property (p_oe_needs_sel) else $error("output driven while deselected");
  a_oe_on_edge:
    assert property (p_oe_on_edge) else $error("output enabled off a rising clock");
  a_sclk_high:
    assert property (p_sclk_high) else $error("link clock high phase wrong");
  a_di_hold:
    assert property (p_di_hold) else $error("data changed in high phase");
  a_sel_gap:
    assert property (p_sel_gap) else $error("select low gap too short");
  a_busy_status:
    assert property (p_busy_status) else $error("status high while busy");
  a_idle_standby:
    assert property (p_idle_standby) else $error("no standby when idle");
  a_sel_quiet:
    assert property (p_sel_quiet) else $error("output enabled as select rose");
  a_prog_len:
    assert property (p_prog_len) else $error("programming time wrong");
endmodule

// *** test/serial_eeprom_pin_protocol_bench.sv ***
// Self-checking bench: master and memory device joined over the link
`include "seep_defs.svh"
`define SEEP_CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module serial_eeprom_pin_protocol_bench
  import seep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIM  = 20000;
  localparam int PROG = 50;

  logic        clk = 1'b0;
  logic        rst;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [29:0] cmd_bits;
  logic [6:0]  cmd_len;
  logic [6:0]  cmd_rlen;
  logic        cmd_poll;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        org_val;
  logic        org_drive;
  logic        pe_val;
  logic        pe_drive;
  logic        dev_busy;
  logic        dev_standby;
  logic [32:0] exp_q[$];
  logic [32:0] exp_e;
  logic [15:0] seed;
  logic [15:0] da;
  logic [15:0] db;
  int          errors;
  int          tests_run;
  int          t;

  always #50 clk = ~clk;

  seep_if u_seep_if ();
  seep_dev #(.PROG_CYCLES(PROG)) u_seep_dev (.clk(clk), .rst(rst), .lnk(u_seep_if.dev),
    .standby(dev_standby), .busy(dev_busy));
  seep_host u_seep_host (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_bits(cmd_bits), .cmd_len(cmd_len), .cmd_rlen(cmd_rlen), .cmd_poll(cmd_poll),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .org_val(org_val), .org_drive(org_drive),
    .pe_val(pe_val), .pe_drive(pe_drive), .lnk(u_seep_if.host));
  seep_properties #(.PROG_CYCLES(PROG)) u_seep_properties (.clk(clk), .rst(rst),
    .sel(u_seep_if.sel), .sclk(u_seep_if.sclk), .di(u_seep_if.di), .so_o(u_seep_if.so_o),
    .so_oe(u_seep_if.so_oe), .busy(dev_busy), .standby(dev_standby));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= LIM) begin
      errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      tally_and_finish();
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Frame as {length, bits left-aligned}, idle zeros before and after
  function automatic logic [36:0] mk(input logic [1:0] op, input logic [10:0] a,
      input logic [15:0] d, input logic x8, input logic hasd, input int pre, input int post);
    logic [63:0] v;
    int          aw;
    int          dw;
    int          n;
    aw = x8 ? `SEEP_AW8 : `SEEP_AW16;
    dw = x8 ? `SEEP_DW8 : `SEEP_DW16;
    v  = (64'h4 | 64'(op)) << aw | (64'(a) & ((64'h1 << aw) - 64'h1));
    n  = 3 + aw;
    if (hasd) begin
      v = (v << dw) | (x8 ? 64'(d[7:0]) : 64'(d));
      n = n + dw;
    end
    n = n + pre + post;
    v = v << (30 - n + post);
    return {7'(n), v[29:0]};
  endfunction

  task automatic send(input logic [36:0] c, input logic [6:0] rl, input logic poll,
                      input logic [32:0] e);
    for (t = 0; t < LIM && cmd_ready !== 1'b1; t++) begin
      @(negedge clk);
    end
    guard(t);
    {cmd_len, cmd_bits} = c;
    cmd_rlen  = rl;
    cmd_poll  = poll;
    cmd_valid = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (t = 0; t < LIM && exp_q.size() != 0; t++) begin
      @(negedge clk);
    end
    guard(t);
  endtask

  task automatic rd(input logic [10:0] a, input logic x8, input int words, input int pre,
                    input logic [31:0] e);
    send(mk(`SEEP_OP_READ, a, 16'h0000, x8, 1'b0, pre, 0),
         7'(1 + words * (x8 ? 8 : 16)), 1'b0, {1'b0, e});
  endtask

  task automatic prog(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                      input logic hasd, input logic poll, input int post);
    send(mk(op, a, d, org_drive, hasd, 0, post), 7'h00, poll, 33'h1_0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED rsp_valid expected none seen pulse");
      end else begin
        exp_e = exp_q.pop_front();
        if (exp_e[32] === 1'b0) `SEEP_CHK("rsp_data", exp_e[31:0], rsp_data)
      end
    end
  end

  initial begin
    rst       = 1'b1;
    cmd_valid = 1'b0;
    cmd_bits  = 30'h0;
    cmd_len   = 7'h00;
    cmd_rlen  = 7'h00;
    cmd_poll  = 1'b0;
    org_val   = 1'b0;
    org_drive = 1'b0;
    pe_val    = 1'b0;
    pe_drive  = 1'b0;
    errors    = 0;
    tests_run = 0;
    seed      = 16'h004F;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Idle clocks before the start bit
    rd(11'h005, 1'b0, 1, 3, 32'h0000FFFF);
    prog(`SEEP_OP_WRITE, 11'h005, 16'h1234, 1'b1, 1'b1, 0);
    // Enable, with surplus clocks after the last bit
    prog(`SEEP_OP_EXT, 11'h300, 16'h0000, 1'b0, 1'b0, 4);
    pe_drive = 1'b1;
    prog(`SEEP_OP_WRITE, 11'h005, 16'h1234, 1'b1, 1'b1, 0);
    rd(11'h005, 1'b0, 1, 0, 32'h0000FFFF);
    pe_val   = 1'b1;
    seed = lfsr(seed);
    da   = seed;
    seed = lfsr(seed);
    db   = seed;
    prog(`SEEP_OP_WRITE, 11'h005, da, 1'b1, 1'b1, 0);
    // Select drops at once; the cycle must still finish
    prog(`SEEP_OP_WRITE, 11'h006, db, 1'b1, 1'b0, 0);
    for (t = 0; t < LIM && dev_busy !== 1'b1; t++) begin
      @(negedge clk);
    end
    guard(t);
    // Let deselect cross into the device while the cycle still runs
    repeat (4) @(negedge clk);
    `SEEP_CHK("busy", 1'b1, dev_busy)
    `SEEP_CHK("standby", 1'b0, dev_standby)
    for (t = 0; t < LIM && dev_standby !== 1'b1; t++) begin
      @(negedge clk);
    end
    guard(t);
    `SEEP_CHK("busy", 1'b0, dev_busy)
    rd(11'h005, 1'b0, 2, 0, {da, db});
    pe_drive = 1'b0;
    // Byte mode: even byte is the low half
    org_drive = 1'b1;
    prog(`SEEP_OP_WRITE, 11'h00A, 16'h005A, 1'b1, 1'b1, 0);
    rd(11'h00A, 1'b1, 2, 0, {16'h0000, 8'h5A, da[15:8]});
    // Width strap driven high selects whole words
    org_val = 1'b1;
    rd(11'h005, 1'b0, 1, 0, {16'h0000, da[15:8], 8'h5A});
    org_drive = 1'b0;
    rd(11'h005, 1'b0, 1, 0, {16'h0000, da[15:8], 8'h5A});
    // Erase, write-all, erase-all, disable
    prog(`SEEP_OP_ERASE, 11'h005, 16'h0000, 1'b0, 1'b1, 0);
    rd(11'h005, 1'b0, 1, 0, 32'h0000FFFF);
    prog(`SEEP_OP_EXT, 11'h100, db, 1'b1, 1'b1, 0);
    rd(11'h3FF, 1'b0, 1, 0, {16'h0000, db});
    prog(`SEEP_OP_EXT, 11'h200, 16'h0000, 1'b0, 1'b1, 0);
    rd(11'h3FF, 1'b0, 1, 0, 32'h0000FFFF);
    prog(`SEEP_OP_EXT, 11'h000, 16'h0000, 1'b0, 1'b0, 0);
    prog(`SEEP_OP_WRITE, 11'h3FF, da, 1'b1, 1'b1, 0);
    rd(11'h3FF, 1'b0, 1, 0, 32'h0000FFFF);
    tally_and_finish();
  end
endmodule
